/* dsm_cfg.svh */
`ifndef DSM_CFG_SVH
`define DSM_CFG_SVH
// Register offsets (chosen, byte-wide registers on a plain port)
`define DSM_OFF_CTRL      4'h0
`define DSM_OFF_MSRC      4'h1
`define DSM_OFF_CARH      4'h2
`define DSM_OFF_CARL      4'h3
// Control register fields
`define DSM_CTRL_EN       7
`define DSM_CTRL_OPOL     4
`define DSM_CTRL_OUT      3
`define DSM_CTRL_SBIT     0
// Carrier register fields
`define DSM_CAR_POL       6
`define DSM_CAR_SYNC      5
// Writable masks
`define DSM_MASK_CTRL     8'h91
`define DSM_MASK_MSRC     8'h0F
`define DSM_MASK_CAR      8'h6F
// Reset values
`define DSM_RST_CTRL      8'h00
`define DSM_RST_SRC       8'h00
// Source codes
`define DSM_MOD_SOFT      4'h0
`define DSM_CAR_GND       4'h0
`define DSM_CAR_NC        4'h9
`define DSM_MOD_RSVD      4'h9
`endif

/* dsm_pkg.sv */
package dsm_pkg;
   typedef logic [7:0] dsm_byte_t;
   typedef logic [3:0] dsm_sel_t;
   typedef enum logic {DSM_CAR_LOW, DSM_CAR_HIGH} dsm_car_e;
endpackage : dsm_pkg

/* dsm_src_if.sv */
`timescale 1ns/1ns
interface dsm_src_if;
   logic [15:0] sources;
   logic [3:0]  sel;
   logic        invert;
   logic        value;
   modport user (output sources, output sel, output invert, input value);
   modport mux  (input sources, input sel, input invert, output value);
endinterface : dsm_src_if

/* dsm_src_mux.sv */
`timescale 1ns/1ns
module dsm_src_mux (
   dsm_src_if.mux port_m
);
   import dsm_pkg::*;
   assign port_m.value = port_m.sources[port_m.sel] ^ port_m.invert;
endmodule : dsm_src_mux

/* dsm_sync_gate.sv */
`timescale 1ns/1ns
`include "dsm_cfg.svh"
module dsm_sync_gate (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic want,
   input  wire logic sync_en,
   input  wire logic carrier,
   output logic      active
);
   import dsm_pkg::*;
   logic car_prev_reg;
   logic gate_reg;
   logic fall;
   assign fall = car_prev_reg & ~carrier;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) car_prev_reg <= 1'b0;
      else car_prev_reg <= carrier;
   end
   // Synced carrier turns on and off only on its falling edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) gate_reg <= 1'b0;
      else if (!sync_en || fall) gate_reg <= want;
   end
   assign active = sync_en ? gate_reg : want;
endmodule : dsm_sync_gate

/* dsm_top.sv */
`timescale 1ns/1ns
`include "dsm_cfg.svh"
// What this block does
// - High carrier inverted when its invert bit set
// - Low carrier inverted when its invert bit set
// - Software bit can be modulator signal
// - Bit 4 inverts output; idle level equals bit 4
// - Runs unchanged in sleep
// - rst_n disables module, control defaults restored
// - Bit 7 enables mixing; else no output
// - Bit 3 reads live output, read only
// - Software bit used only when selected
// - Modulator source encoding, code 9 reserved
// - Carrier source encoding, code 9 unconnected
// - High carrier sync waits falling edge
// - Unimplemented bits read zero, ignore writes
// - Control resets zero; selects keep otherwise
// - Output is high carrier while modulator high, else low carrier
// - Synced carrier finishes until falling edge
// - Low carrier sync waits falling edge
// - Low carrier select shares same encoding
module dsm_top (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic [15:0] mod_sources,
   input  wire logic [15:0] car_sources,
   output logic             mod_out
);
   import dsm_pkg::*;

   // ************************************
   // Registers
   // ************************************
   dsm_pkg::dsm_byte_t ctrl_reg, msrc_reg, carh_reg, carl_reg;
   dsm_pkg::dsm_byte_t rdata_next;
   logic               mixed;

   // Control clears on rst_n; power-on alone leaves it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ctrl_reg <= `DSM_RST_CTRL;
      else if (wr && addr == `DSM_OFF_CTRL) ctrl_reg <= wdata & `DSM_MASK_CTRL;
   end

   // Select registers only clear on power-on; other resets keep them
   always_ff @(posedge clock or negedge por_n) begin
      if (!por_n) begin
         msrc_reg <= `DSM_RST_SRC;
         carh_reg <= `DSM_RST_SRC;
         carl_reg <= `DSM_RST_SRC;
      end else if (wr) begin
         if (addr == `DSM_OFF_MSRC) msrc_reg <= wdata & `DSM_MASK_MSRC;
         if (addr == `DSM_OFF_CARH) carh_reg <= wdata & `DSM_MASK_CAR;
         if (addr == `DSM_OFF_CARL) carl_reg <= wdata & `DSM_MASK_CAR;
      end
   end

   // ************************************
   // Source selection
   // ************************************
   logic        en;
   logic [15:0] mod_vec;
   logic        modv, chv, clv, ch_act, cl_act;
   dsm_src_if   mod_if();
   dsm_src_if   ch_if();
   dsm_src_if   cl_if();

   assign en = ctrl_reg[`DSM_CTRL_EN];

   // Code 0 is the software bit, code 9 reserved
   always_comb begin
      mod_vec                = mod_sources;
      mod_vec[`DSM_MOD_SOFT] = ctrl_reg[`DSM_CTRL_SBIT];
      mod_vec[`DSM_MOD_RSVD] = 1'b0;
   end

   // Disabled forces software bit and ground carriers, saving power
   assign mod_if.sources = mod_vec;
   assign mod_if.sel     = en ? msrc_reg[3:0] : `DSM_MOD_SOFT;
   assign mod_if.invert  = 1'b0;
   assign modv           = mod_if.value;

   logic [15:0] car_vec;
   always_comb begin
      car_vec              = car_sources;
      car_vec[`DSM_CAR_GND] = 1'b0;
      car_vec[`DSM_CAR_NC]  = 1'b0;
   end

   assign ch_if.sources = car_vec;
   assign ch_if.sel     = en ? carh_reg[3:0] : `DSM_CAR_GND;
   assign ch_if.invert  = carh_reg[`DSM_CAR_POL];
   assign chv           = ch_if.value;
   assign cl_if.sources = car_vec;
   assign cl_if.sel     = en ? carl_reg[3:0] : `DSM_CAR_GND;
   assign cl_if.invert  = carl_reg[`DSM_CAR_POL];
   assign clv           = cl_if.value;

   dsm_src_mux u_mod (.port_m(mod_if));
   dsm_src_mux u_ch  (.port_m(ch_if));
   dsm_src_mux u_cl  (.port_m(cl_if));

   // ************************************
   // Carrier synchronisation
   // ************************************
   // Edges are found on the sampled carrier, so a carrier faster than
   // the clock aliases; the gate is exact only for slower carriers.
   dsm_sync_gate u_hs (
      .clock   (clock),
      .rst_n   (rst_n),
      .want    (modv & en),
      .sync_en (carh_reg[`DSM_CAR_SYNC]),
      .carrier (chv),
      .active  (ch_act)
   );
   dsm_sync_gate u_ls (
      .clock   (clock),
      .rst_n   (rst_n),
      .want    (~modv & en),
      .sync_en (carl_reg[`DSM_CAR_SYNC]),
      .carrier (clv),
      .active  (cl_act)
   );

   // ************************************
   // Mixing and output
   // ************************************
   // No sleep gating: logic runs on every clock
   assign mixed = en & ((ch_act & chv) | (cl_act & clv));

   // Polarity after mixing; disabled idles at polarity level
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) mod_out <= 1'b0;
      else mod_out <= mixed ^ ctrl_reg[`DSM_CTRL_OPOL];
   end

   // ************************************
   // Read port
   // ************************************
   // Status bit is the registered pin level, one cycle behind the mix,
   // so it trades exactness for a glitch-free read value.
   always_comb begin
      rdata_next = 8'h00;
      if (rd) begin
         unique case (addr)
            `DSM_OFF_CTRL: begin
               rdata_next                 = ctrl_reg;
               rdata_next[`DSM_CTRL_OUT] = mod_out;
            end
            `DSM_OFF_MSRC: rdata_next = msrc_reg;
            `DSM_OFF_CARH: rdata_next = carh_reg;
            `DSM_OFF_CARL: rdata_next = carl_reg;
            default:       rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) rdata <= 8'h00;
      else rdata <= rdata_next;
   end

   // ************************************
   // Checks
   // ************************************
   a_idle_level: assert property (@(posedge clock) disable iff (!rst_n)
      !en && !$past(en) |-> mod_out == $past(ctrl_reg[`DSM_CTRL_OPOL]))
      else $error("idle level wrong");

   a_out_mix: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 mod_out == ($past(mixed) ^ $past(ctrl_reg[`DSM_CTRL_OPOL])))
      else $error("output mismatch");

   a_rd_view: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `DSM_OFF_CTRL |=> rdata[`DSM_CTRL_OUT] == $past(mod_out))
      else $error("status view wrong");

   a_unimpl_zero: assert property (@(posedge clock) disable iff (!rst_n)
      (ctrl_reg & ~`DSM_MASK_CTRL) == 8'h00 && (msrc_reg & ~`DSM_MASK_MSRC) == 8'h00)
      else $error("unimplemented bit set");

   a_soft_bit: assert property (@(posedge clock) disable iff (!rst_n)
      en && msrc_reg[3:0] == `DSM_MOD_SOFT |-> modv == ctrl_reg[`DSM_CTRL_SBIT])
      else $error("soft bit not used");

   a_hi_inv: assert property (@(posedge clock) disable iff (!rst_n)
      en |-> chv == ((carh_reg[3:0] == `DSM_CAR_GND || carh_reg[3:0] == `DSM_CAR_NC ?
         1'b0 : car_sources[carh_reg[3:0]]) ^ carh_reg[`DSM_CAR_POL]))
      else $error("high invert wrong");

   a_lo_inv: assert property (@(posedge clock) disable iff (!rst_n)
      en |-> clv == ((carl_reg[3:0] == `DSM_CAR_GND || carl_reg[3:0] == `DSM_CAR_NC ?
         1'b0 : car_sources[carl_reg[3:0]]) ^ carl_reg[`DSM_CAR_POL]))
      else $error("low invert wrong");

   a_nosync_hi: assert property (@(posedge clock) disable iff (!rst_n)
      !carh_reg[`DSM_CAR_SYNC] |-> ch_act == (modv & en))
      else $error("high unsynced gate wrong");

   a_ctrl_write: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `DSM_OFF_CTRL |=> ctrl_reg == ($past(wdata) & `DSM_MASK_CTRL))
      else $error("control write lost");

   // ************************************
   // Register checks
   // ************************************
   a_ctrl_reset: assert property (@(posedge clock)
      !rst_n |-> ctrl_reg == `DSM_RST_CTRL && mod_out == 1'b0 && rdata == 8'h00)
      else $error("reset left control state");

   a_por_clear: assert property (@(posedge clock)
      !por_n |-> msrc_reg == `DSM_RST_SRC && carh_reg == `DSM_RST_SRC &&
         carl_reg == `DSM_RST_SRC)
      else $error("power-on left select state");

   a_sel_keep: assert property (@(posedge clock) disable iff (!por_n)
      !wr |=> msrc_reg == $past(msrc_reg) && carh_reg == $past(carh_reg) &&
         carl_reg == $past(carl_reg))
      else $error("select register changed without write");

   a_car_unimpl: assert property (@(posedge clock) disable iff (!rst_n)
      (carh_reg & ~`DSM_MASK_CAR) == 8'h00 && (carl_reg & ~`DSM_MASK_CAR) == 8'h00)
      else $error("unimplemented carrier bit set");

   a_unmapped_rd: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr > `DSM_OFF_CARL |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   a_wr_ignored: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr > `DSM_OFF_CARL |=> ctrl_reg == $past(ctrl_reg) &&
         msrc_reg == $past(msrc_reg) && carh_reg == $past(carh_reg) &&
         carl_reg == $past(carl_reg))
      else $error("unmapped write landed");

   a_rd_select: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `DSM_OFF_MSRC |=> rdata == $past(msrc_reg))
      else $error("source select read wrong");

   // ************************************
   // Source checks and unsynced low gate check
   // ************************************
   a_mod_pin: assert property (@(posedge clock) disable iff (!rst_n)
      en && msrc_reg[3:0] != `DSM_MOD_SOFT && msrc_reg[3:0] != `DSM_MOD_RSVD |->
         modv == mod_sources[msrc_reg[3:0]])
      else $error("modulator source wrong");

   a_mod_rsvd: assert property (@(posedge clock) disable iff (!rst_n)
      en && msrc_reg[3:0] == `DSM_MOD_RSVD |-> !modv)
      else $error("reserved modulator code active");

   a_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !en |-> !mixed && modv == ctrl_reg[`DSM_CTRL_SBIT])
      else $error("disabled module still mixing");

   a_nosync_lo: assert property (@(posedge clock) disable iff (!rst_n)
      !carl_reg[`DSM_CAR_SYNC] |-> cl_act == (~modv & en))
      else $error("low unsynced gate wrong");

   // ************************************
   // Sync checks
   // ************************************
   // These follow the sampled carrier, as the gates do; the first edge
   // after reset is skipped since the edge memory starts cleared.
   a_hi_hold: assert property (@(posedge clock) disable iff (!rst_n)
      carh_reg[`DSM_CAR_SYNC] && $past(carh_reg[`DSM_CAR_SYNC]) &&
      !($past(chv, 2) && !$past(chv)) |-> ch_act == $past(ch_act))
      else $error("synced high gate moved off edge");

   a_hi_fall: assert property (@(posedge clock) disable iff (!rst_n)
      carh_reg[`DSM_CAR_SYNC] && $past(carh_reg[`DSM_CAR_SYNC]) &&
      $past(rst_n, 2) && $past(chv, 2) && !$past(chv) |-> ch_act == $past(modv & en))
      else $error("synced high gate missed edge");

   a_lo_hold: assert property (@(posedge clock) disable iff (!rst_n)
      carl_reg[`DSM_CAR_SYNC] && $past(carl_reg[`DSM_CAR_SYNC]) &&
      !($past(clv, 2) && !$past(clv)) |-> cl_act == $past(cl_act))
      else $error("synced low gate moved off edge");

   a_lo_fall: assert property (@(posedge clock) disable iff (!rst_n)
      carl_reg[`DSM_CAR_SYNC] && $past(carl_reg[`DSM_CAR_SYNC]) &&
      $past(rst_n, 2) && $past(clv, 2) && !$past(clv) |-> cl_act == $past(~modv & en))
      else $error("synced low gate missed edge");

   // ************************************
   // Output checks
   // ************************************
   a_idle_out: assert property (@(posedge clock) disable iff (!rst_n)
      !mixed |=> mod_out == $past(ctrl_reg[`DSM_CTRL_OPOL]))
      else $error("idle output level wrong");

   a_mix_plain: assert property (@(posedge clock) disable iff (!rst_n)
      en && !carh_reg[`DSM_CAR_SYNC] && !carl_reg[`DSM_CAR_SYNC] |->
         mixed == (modv ? chv : clv))
      else $error("carrier choice wrong");
endmodule : dsm_top

/* dsm_pin_sink.sv */
`timescale 1ns/1ns
// ****************************************
// Load on the modulated pin
// ****************************************
// The pin is sampled like a plain register input, so a short
// glitch between clock edges goes unseen.
module dsm_pin_sink (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level_reg
);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= pin;
      end
   end
endmodule : dsm_pin_sink

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import dsm_pkg::*;
   typedef struct {
      dsm_byte_t   c, m, h, l;
      logic [15:0] ms, cs;
      logic        e;
   } dsm_row_s;
   logic        clock, rst_n, por_n, wr, rd, mod_out, level;
   logic [3:0]  addr;
   dsm_byte_t   wdata, rdata;
   logic [15:0] mod_src, car_src;
   int          err_total, checks;
   dsm_row_s    rows[13] = '{
      '{8'h81, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0002, 1'b1},
      '{8'h80, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0004, 1'b1},
      '{8'h80, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0002, 1'b0},
      '{8'h91, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0002, 1'b0},
      '{8'h01, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0002, 1'b0},
      '{8'h10, 8'h0, 8'h01, 8'h02, 16'h0000, 16'h0002, 1'b1},
      '{8'h81, 8'h0, 8'h41, 8'h02, 16'h0000, 16'h0000, 1'b1},
      '{8'h80, 8'h0, 8'h01, 8'h42, 16'h0000, 16'h0000, 1'b1},
      '{8'h80, 8'h1, 8'h01, 8'h02, 16'h0002, 16'h0002, 1'b1},
      '{8'h81, 8'h9, 8'h01, 8'h0A, 16'hFFFF, 16'h0400, 1'b1},
      '{8'h81, 8'h0, 8'h00, 8'h02, 16'h0000, 16'hFFFF, 1'b0},
      '{8'h81, 8'h0, 8'h09, 8'h02, 16'h0000, 16'hFFFF, 1'b0},
      '{8'h80, 8'hF, 8'h0B, 8'h00, 16'h8000, 16'h0800, 1'b1}};

   dsm_top u_dut (.clock(clock), .rst_n(rst_n), .por_n(por_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mod_sources(mod_src),
      .car_sources(car_src), .mod_out(mod_out));
   dsm_pin_sink u_sink (.clock(clock), .rst_n(rst_n), .pin(mod_out), .level_reg(level));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic chk(input string nm, input dsm_byte_t seen, input dsm_byte_t exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic bus_wr(input logic [3:0] a, input dsm_byte_t d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, input dsm_byte_t exp);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk("rdata", rdata, exp);
   endtask : bus_rd

   // Sink lags the pin by a cycle, so settle long enough for both
   task automatic drv(input logic [15:0] ms, input logic [15:0] cs);
      @(posedge clock);
      mod_src <= ms;
      car_src <= cs;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask : drv

   task automatic do_reset(input logic por);
      @(posedge clock);
      rst_n <= 1'b0;
      por_n <= por;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      por_n <= 1'b1;
   endtask : do_reset

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (5000) @(posedge clock);
      err_total++;
      complete_run();
   end

   initial begin
      {rst_n, por_n, wr, rd, addr, wdata, mod_src, car_src} = '0;
      err_total = 0;
      checks    = 0;
      do_reset(1'b0);
      // ****************************************
      // Ordinary mixing cases
      // ****************************************
      foreach (rows[i]) begin
         bus_wr(4'h0, rows[i].c);
         bus_wr(4'h1, rows[i].m);
         bus_wr(4'h2, rows[i].h);
         bus_wr(4'h3, rows[i].l);
         drv(rows[i].ms, rows[i].cs);
         chk("pin", {7'h00, level}, {7'h00, rows[i].e});
         bus_rd(4'h0, (rows[i].c & 8'h91) | {4'h0, rows[i].e, 3'h0});
      end
      $display("test table done");
      // ****************************************
      // Synchronised carriers
      // ****************************************
      bus_wr(4'h1, 8'h01);
      bus_wr(4'h2, 8'h21);
      bus_wr(4'h3, 8'h02);
      bus_wr(4'h0, 8'h80);
      drv(16'h0002, 16'h0002);
      drv(16'h0002, 16'h0000);
      drv(16'h0002, 16'h0002);
      chk("sync high on", {7'h00, level}, 8'h01);
      drv(16'h0000, 16'h0002);
      chk("sync high hold", {7'h00, level}, 8'h01);
      drv(16'h0000, 16'h0000);
      chk("sync high end", {7'h00, level}, 8'h00);
      bus_wr(4'h2, 8'h01);
      bus_wr(4'h3, 8'h22);
      drv(16'h0000, 16'h0004);
      drv(16'h0000, 16'h0000);
      drv(16'h0000, 16'h0004);
      drv(16'h0002, 16'h0004);
      chk("sync low hold", {7'h00, level}, 8'h01);
      drv(16'h0002, 16'h0000);
      chk("sync low end", {7'h00, level}, 8'h00);
      $display("test sync done");
      // ****************************************
      // Reserved bits and resets
      // ****************************************
      bus_wr(4'h0, 8'h76);
      bus_wr(4'h1, 8'hFF);
      bus_wr(4'h2, 8'hFF);
      bus_wr(4'h3, 8'hFF);
      bus_wr(4'h4, 8'hFF);
      bus_rd(4'h0, 8'h18);
      bus_rd(4'h1, 8'h0F);
      bus_rd(4'h2, 8'h6F);
      bus_rd(4'h3, 8'h6F);
      bus_rd(4'h4, 8'h00);
      bus_wr(4'h0, 8'h91);
      do_reset(1'b1);
      bus_rd(4'h0, 8'h00);
      bus_rd(4'h1, 8'h0F);
      bus_rd(4'h2, 8'h6F);
      do_reset(1'b0);
      bus_rd(4'h1, 8'h00);
      bus_rd(4'h3, 8'h00);
      $display("test reset done");
      complete_run();
   end
endmodule : tb_top
